// [pirc_cfg.svh]
`ifndef PIRC_CFG_SVH
`define PIRC_CFG_SVH
// ---------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ---------------------------------------------------------------
`define PIRC_OFF_ENTRY0     12'h000
`define PIRC_OFF_ENTRY1     12'h004
`define PIRC_OFF_ENTRY2     12'h008
`define PIRC_OFF_ENTRY3     12'h00c
`define PIRC_OFF_REQ        12'h010
`define PIRC_OFF_RESULT     12'h014
`define PIRC_OFF_DESC_HI    12'h018
`define PIRC_OFF_STATUS     12'h01c
`define PIRC_OFF_CLEAR      12'h020
`define PIRC_OFF_ENABLE     12'h024
// ---------------------------------------------------------------
// Entry field positions
// ---------------------------------------------------------------
`define PIRC_BIT_PRESENT    0
`define PIRC_BIT_FAULT_OFF  1
`define PIRC_BIT_MODE       15
`define PIRC_ALLOW_LSB      64
`define PIRC_ALLOW_MSB      79
`define PIRC_QUAL_LSB       80
`define PIRC_CHK_LSB        82
`define PIRC_RSV_LSB        84
`define PIRC_RSV_MSB        95
`define PIRC_DESC_LSB       96
`define PIRC_DESC_MSB       127
// ---------------------------------------------------------------
// Field encodings and reset values
// ---------------------------------------------------------------
`define PIRC_CHK_NONE       2'h0
`define PIRC_CHK_MATCH      2'h1
`define PIRC_CHK_BUS        2'h2
`define PIRC_QUAL_ALL       2'h0
`define PIRC_QUAL_SKIP2     2'h1
`define PIRC_QUAL_SKIP21    2'h2
`define PIRC_QUAL_SKIP210   2'h3
`define PIRC_RST_WORD       32'h0000_0000
`define PIRC_HOST_WIDTH_DEF 48
`endif

// [pirc_pkg.sv]
package pirc_pkg;
   // Outcome of one requester-id check
   typedef struct packed {
      logic accept;   // Request may proceed
      logic block;    // Request blocked
      logic fault;    // Fault to be reported
      logic posted;   // Entry in posted format
   } pirc_verdict_t;

   // Status / enable bit layout
   typedef struct packed {
      logic reserved_err;  // Reserved encoding seen
      logic fault;         // Reported source fault
      logic done;          // A check completed
   } pirc_events_t;

   // Check state machine
   typedef enum logic [1:0] {
      PIRC_IDLE  = 2'b00,
      PIRC_CHECK = 2'b01
   } pirc_state_t;
endpackage

// [pirc_sid_match.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pirc_cfg.svh"
// ---------------------------------------------------------------
// Requester-id comparison, combinational
// ---------------------------------------------------------------
module pirc_sid_match (
   input  wire logic [127:0]       entry,
   input  wire logic [15:0]        req_id,
   output var  pirc_pkg::pirc_verdict_t verdict
);
   logic [1:0]  chk_type; // Source check type
   logic [1:0]  qual;     // Source mask qualifier
   logic [15:0] allowed;  // Allowed requester
   logic [15:0] mask;     // Bits that take part
   logic        match;    // Comparison outcome
   logic        bad;      // Reserved encoding

   // Qualifier to mask, low three bits dropped in steps
   function automatic logic [15:0] qual_mask(input logic [1:0] q);
      case (q)
         `PIRC_QUAL_ALL:    qual_mask = 16'hffff;
         `PIRC_QUAL_SKIP2:  qual_mask = 16'hfffb;
         `PIRC_QUAL_SKIP21: qual_mask = 16'hfff9;
         default:           qual_mask = 16'hfff8;
      endcase
   endfunction

   always_comb begin
      chk_type = entry[`PIRC_CHK_LSB +: 2];
      qual     = entry[`PIRC_QUAL_LSB +: 2];
      allowed  = entry[`PIRC_ALLOW_MSB:`PIRC_ALLOW_LSB];
      mask     = qual_mask(qual);
      match    = 1'b0;
      bad      = 1'b0;
      case (chk_type)
         `PIRC_CHK_NONE:  match = 1'b1;
         `PIRC_CHK_MATCH: match = ((req_id ^ allowed) & mask) == 16'h0000;
         `PIRC_CHK_BUS:   match = (req_id[15:8] >= allowed[15:8]) &&
                                  (req_id[15:8] <= allowed[7:0]);
         default: begin
            // Reserved type: treated as a failed check
            match = 1'b0;
            bad   = 1'b1;
         end
      endcase
      verdict.posted = entry[`PIRC_BIT_MODE];
      // Allow, qualifier and check-type fields only count when present is set
      if (!entry[`PIRC_BIT_PRESENT]) begin
         verdict.accept = 1'b0;
         verdict.block  = 1'b1;
         verdict.fault  = !entry[`PIRC_BIT_FAULT_OFF];
      end else begin
         verdict.accept = match && !bad;
         verdict.block  = !(match && !bad);
         verdict.fault  = !(match && !bad) && !entry[`PIRC_BIT_FAULT_OFF];
      end
   end
endmodule
`default_nettype wire

// [pirc_top.sv]
// Summary of operation
// - Entry bits 127:96 give descriptor address 63:32
// - Address bits above host width read zero
// - Upper fields evaluated only when present
// - Check type 00 skips; 11 reserved
// - Type 01 compares masked requester id
// - Type 10 checks bus within range
// - Qualifier used only with type 01
// - Qualifier 00 compares all 16 bits
// - Qualifier 01 ignores bit 2
// - Qualifier 10 ignores bits 2, 1
// - Qualifier 11 ignores three low bits
// - Qualifier needs present and type 01
// - Absent entry blocks every request
// - Bits 79:64 hold allowed requester
// - Mode bit 15 selects posted format
`timescale 1ns/10ps
`default_nettype none
`include "pirc_cfg.svh"
module pirc_top #(
   parameter int HOST_ADDR_WIDTH = `PIRC_HOST_WIDTH_DEF  // Platform width
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        req_valid,
   input  wire logic [15:0] req_id,
   output logic             req_accept,
   output logic             req_block,
   output logic             irq
);
   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (HOST_ADDR_WIDTH < 32 || HOST_ADDR_WIDTH > 64) begin : g_bad
      $error("host address width out of range");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [127:0]          entry;      // Cached table entry
      logic [1:0]            req_v_sync; // Request valid sync
      logic                  req_v_old;  // For edge detect
      logic [1:0][15:0]      req_id_sync; // Requester id sync
      logic [15:0]           req_id;     // Captured requester
      logic [31:0]           desc_hi;    // Masked address high
      logic                  accept;     // Last verdict accept
      logic                  block;      // Last verdict block
      logic                  posted;     // Last verdict format
      pirc_pkg::pirc_events_t status;    // Sticky events
      pirc_pkg::pirc_events_t enable;    // Interrupt enables
      pirc_pkg::pirc_state_t  state;     // Check sequencer
      logic [31:0]           prdata;     // Read data
      logic                  pready;     // Bus answer
      logic                  pslverr;    // Bus error
      logic                  irq;        // Interrupt out
   } pirc_state_reg_t;

   pirc_state_reg_t         s_r;     // Registered state
   pirc_state_reg_t         s_nxt;   // Next state
   pirc_pkg::pirc_verdict_t verdict; // Compare result
   pirc_pkg::pirc_events_t  ev;      // Events this cycle
   pirc_pkg::pirc_events_t  clr;     // Clear strobes
   logic                    wr_acc;  // Write access phase
   logic                    rd_acc;  // Read access phase
   logic                    req_go;  // Rising request edge
   logic [31:0]             haw_mask;// Address high mask

   // Address bits 63:32 kept below the host width
   function automatic logic [31:0] high_mask(input int host_addr_width);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         m[i] = (i + 32) < host_addr_width;
      end
      return m;
   endfunction

   assign haw_mask = high_mask(HOST_ADDR_WIDTH);

   // ------------------------------------------------------------
   // Compare unit
   // ------------------------------------------------------------
   pirc_sid_match u_match (
      .entry   (s_r.entry),
      .req_id  (s_r.req_id),
      .verdict (verdict)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      s_nxt  = s_r;
      wr_acc = psel && penable && pwrite;
      rd_acc = psel && penable && !pwrite;
      ev     = '0;
      clr    = '0;
      // Pin input: two flops before the edge detector
      s_nxt.req_v_sync = {s_r.req_v_sync[0], req_valid};
      s_nxt.req_v_old  = s_r.req_v_sync[1];
      // Id pins cross too; they settle before the strobe rises
      s_nxt.req_id_sync = {s_r.req_id_sync[0], req_id};
      req_go = s_r.req_v_sync[1] && !s_r.req_v_old;
      // Zero-wait APB: answer in the access phase
      s_nxt.pready  = psel && !penable;
      s_nxt.pslverr = 1'b0;
      if (psel && !penable) begin
         s_nxt.prdata = 32'h0000_0000;
         case (paddr)
            `PIRC_OFF_ENTRY0:  s_nxt.prdata = s_r.entry[31:0];
            `PIRC_OFF_ENTRY1:  s_nxt.prdata = s_r.entry[63:32];
            `PIRC_OFF_ENTRY2:  s_nxt.prdata = s_r.entry[95:64];
            `PIRC_OFF_ENTRY3:  s_nxt.prdata = s_r.entry[127:96];
            `PIRC_OFF_REQ:     s_nxt.prdata = {16'h0000, s_r.req_id};
            `PIRC_OFF_RESULT:  s_nxt.prdata = {29'h0, s_r.posted,
                                               s_r.block, s_r.accept};
            `PIRC_OFF_DESC_HI: s_nxt.prdata = s_r.desc_hi;
            `PIRC_OFF_STATUS:  s_nxt.prdata = {29'h0, s_r.status};
            `PIRC_OFF_ENABLE:  s_nxt.prdata = {29'h0, s_r.enable};
            `PIRC_OFF_CLEAR:   s_nxt.prdata = 32'h0000_0000;
            default:           s_nxt.pslverr = 1'b1;
         endcase
      end
      // Register writes, effective at the access edge
      if (wr_acc) begin
         case (paddr)
            `PIRC_OFF_ENTRY0:  s_nxt.entry[31:0]   = pwdata;
            `PIRC_OFF_ENTRY1:  s_nxt.entry[63:32]  = pwdata;
            `PIRC_OFF_ENTRY2:  s_nxt.entry[95:64]  = pwdata;
            `PIRC_OFF_ENTRY3:  s_nxt.entry[127:96] = pwdata;
            `PIRC_OFF_REQ:     s_nxt.req_id        = pwdata[15:0];
            `PIRC_OFF_CLEAR:   clr                 = pwdata[2:0];
            `PIRC_OFF_ENABLE:  s_nxt.enable        = pwdata[2:0];
            default:           s_nxt.entry         = s_r.entry;
         endcase
      end
      // Check sequencer: capture, then evaluate one cycle later
      case (s_r.state)
         pirc_pkg::PIRC_IDLE: begin
            if (req_go || (wr_acc && paddr == `PIRC_OFF_REQ)) begin
               if (req_go) begin
                  s_nxt.req_id = s_r.req_id_sync[1];
               end
               s_nxt.state = pirc_pkg::PIRC_CHECK;
            end
         end
         pirc_pkg::PIRC_CHECK: begin
            s_nxt.accept = verdict.accept;
            s_nxt.block  = verdict.block;
            s_nxt.posted = verdict.posted;
            // Reserved bits 95:84 are not checked by hardware
            if (s_r.entry[`PIRC_BIT_PRESENT]) begin
               s_nxt.desc_hi = s_r.entry[`PIRC_DESC_MSB:`PIRC_DESC_LSB]
                               & haw_mask;
            end else begin
               s_nxt.desc_hi = 32'h0000_0000;
            end
            ev.done         = 1'b1;
            ev.fault        = verdict.fault;
            ev.reserved_err = s_r.entry[`PIRC_BIT_PRESENT] &&
                              (s_r.entry[`PIRC_CHK_LSB +: 2] == 2'h3);
            s_nxt.state = pirc_pkg::PIRC_IDLE;
         end
         default: s_nxt.state = pirc_pkg::PIRC_IDLE;
      endcase
      // Sticky status: a set in the clear cycle wins
      s_nxt.status = (s_r.status & ~clr) | ev;
      s_nxt.irq    = |(s_nxt.status & s_nxt.enable);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata     = s_r.prdata;
   assign pready     = s_r.pready;
   assign pslverr    = s_r.pslverr;
   assign req_accept = s_r.accept;
   assign req_block  = s_r.block;
   assign irq        = s_r.irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Evaluation cycle of the sequencer
   sequence s_check_start;
      s_r.state == pirc_pkg::PIRC_CHECK;
   endsequence

   // Setup cycle of a bus transfer
   sequence s_apb_setup;
      psel && !penable;
   endsequence

   // Answer for one cycle, then quiet again
   sequence s_apb_answer;
      pready ##1 !pready;
   endsequence

   a_absent_blocks: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and !s_r.entry[0] |=> s_r.block && !s_r.accept)
      else $error("absent entry did not block");
   a_skip_accepts: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0] && s_r.entry[83:82] == 2'h0
      |=> s_r.accept)
      else $error("no-check type did not accept");
   a_full_compare: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0] && s_r.entry[83:80] == 4'h4
      |=> s_r.accept == ($past(s_r.req_id) == $past(s_r.entry[79:64])))
      else $error("full compare wrong");
   a_bit2_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0] && s_r.entry[83:80] == 4'h5
      |=> s_r.accept == ((($past(s_r.req_id) ^ $past(s_r.entry[79:64]))
                          & 16'hfffb) == 16'h0))
      else $error("qualifier 01 compare wrong");
   a_low3_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0] && s_r.entry[83:80] == 4'h7
      |=> s_r.accept == ($past(s_r.req_id[15:3]) ==
                         $past(s_r.entry[79:67])))
      else $error("qualifier 11 compare wrong");
   a_bus_range: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0] && s_r.entry[83:82] == 2'h2
      |=> s_r.accept == ($past(s_r.req_id[15:8]) >= $past(s_r.entry[79:72])
                      && $past(s_r.req_id[15:8]) <= $past(s_r.entry[71:64])))
      else $error("bus range wrong");
   a_fault_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and !s_r.entry[0] && !s_r.entry[1]
      |=> s_r.status.fault)
      else $error("fault not flagged");
   a_fault_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[1] && !s_r.status.fault
      |=> !s_r.status.fault)
      else $error("fault flagged although reporting is off");
   a_reserved_type: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0] && s_r.entry[83:82] == 2'h3
      |=> s_r.status.reserved_err && s_r.block && !s_r.accept)
      else $error("reserved check type not refused");
   a_addr_masked: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_check_start and s_r.entry[0]
      |=> s_r.desc_hi == ($past(s_r.entry[127:96]) & haw_mask))
      else $error("descriptor address not masked");
   // Zero wait: the answer stands in the access phase only
   a_pready_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_apb_setup |=> s_apb_answer)
      else $error("bus answer not a single cycle");
   // Level interrupt follows enabled sticky bits
   a_irq_level: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_r.irq == |(s_r.status & s_r.enable))
      else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [pirc_io_dev.sv]
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Interrupt-originating device on the request pins
// ---------------------------------------------------------------
module pirc_io_dev (
   input  wire logic        pclk,
   output logic             req_valid,
   output logic [15:0]      req_id
);
   // Idle pins at time zero
   initial begin
      req_valid = 1'b0;
      req_id    = 16'h0000;
   end

   // One request: id settles a cycle before the strobe rises
   task automatic send(input logic [15:0] id);
      req_id <= id;
      @(posedge pclk);
      req_valid <= 1'b1;
      // Long enough to cross the two-flop synchroniser
      repeat (6) @(posedge pclk);
      req_valid <= 1'b0;
      // Released id lines show a changed pattern, not the old id
      req_id <= ~id;
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pirc_cfg.svh"
module testbench;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, req_valid, req_accept, req_block, irq;
   logic [15:0] req_id;
   int          bad_count, n_checks;
   logic [31:0] q;
   logic        e;
   // Present plus posted format
   localparam logic [31:0] PM = 32'h0000_8001;

   // Narrow host width so the masking shows in the high address
   pirc_top #(.HOST_ADDR_WIDTH(40)) u_pirc_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
      .req_id(req_id), .req_accept(req_accept), .req_block(req_block),
      .irq(irq));
   pirc_io_dev u_pirc_io_dev (
      .pclk(pclk), .req_valid(req_valid), .req_id(req_id));

   // Free-running 250 MHz clock
   always #2 pclk = ~pclk;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Single comparison of any value
   task automatic cmp(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         $display("wrong value %s expected %h seen %h", nm, x, g);
         bad_count++;
      end
   endtask

   // One APB transfer; entered right after a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the slave, never open-ended
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      // Idle edge so the next call never reassigns in this step
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        x;
      apb(1'b1, a, d, r, x);
   endtask

   // Read one register and compare it
   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] x);
      apb(1'b0, a, 32'h0, q, e);
      cmp(nm, x, q);
   endtask

   // Entry word two: reserved bits always written as zero
   function automatic logic [31:0] w2(input logic [1:0] t,
      input logic [1:0] m, input logic [15:0] s);
      return {12'h000, t, m, s};
   endfunction

   // Program entry, start a check by register, look at the verdict
   task automatic run(input logic [31:0] w0, input logic [31:0] ww,
                      input logic [15:0] rid, input logic [2:0] x);
      wr(`PIRC_OFF_ENTRY0, w0);
      wr(`PIRC_OFF_ENTRY2, ww);
      wr(`PIRC_OFF_REQ, {16'h0000, rid});
      // Verdict lands one edge after capture
      repeat (3) @(posedge pclk);
      rdc("result", `PIRC_OFF_RESULT, {29'h0, x});
      cmp("pins", {30'h0, x[1:0]}, {30'h0, req_block, req_accept});
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      bad_count = 0; n_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped place
      rdc("enable", `PIRC_OFF_ENABLE, 32'h0);
      rdc("status", `PIRC_OFF_STATUS, 32'h0);
      apb(1'b0, 12'h028, 32'h0, q, e);
      cmp("slverr", 32'h1, {31'h0, e});
      wr(`PIRC_OFF_ENTRY3, 32'habcd_1234);
      rdc("entry3", `PIRC_OFF_ENTRY3, 32'habcd_1234);
      // Absent entry blocks and hides the address; then present entries: type 00, type 01 per qualifier
      run(32'h0, w2(2'h1, 2'h0, 16'h1234), 16'h1234, 3'b010);
      rdc("desc_hi", `PIRC_OFF_DESC_HI, 32'h0);
      run(PM, w2(2'h0, 2'h0, 16'h1234), 16'hffff, 3'b101);
      rdc("desc_hi", `PIRC_OFF_DESC_HI, 32'h34);
      run(PM, w2(2'h1, 2'h0, 16'h1234), 16'h1234, 3'b101);
      run(PM, w2(2'h1, 2'h0, 16'h1234), 16'h1230, 3'b110);
      run(PM, w2(2'h1, 2'h0, 16'h1234), 16'h9234, 3'b110);
      run(PM, w2(2'h1, 2'h1, 16'h1234), 16'h1230, 3'b101);
      run(PM, w2(2'h1, 2'h1, 16'h1234), 16'h1236, 3'b110);
      run(PM, w2(2'h1, 2'h2, 16'h1234), 16'h1232, 3'b101);
      run(PM, w2(2'h1, 2'h2, 16'h1234), 16'h1235, 3'b110);
      run(PM, w2(2'h1, 2'h3, 16'h1234), 16'h1233, 3'b101);
      run(PM, w2(2'h1, 2'h3, 16'h1234), 16'h123c, 3'b110);
      // Bus range, both bounds inclusive, qualifier ignored; then type 00 without posted format
      run(PM, w2(2'h2, 2'h3, 16'h1030), 16'h1000, 3'b101);
      run(PM, w2(2'h2, 2'h0, 16'h1030), 16'h30ff, 3'b101);
      run(PM, w2(2'h2, 2'h0, 16'h1030), 16'h31ff, 3'b110);
      run(PM, w2(2'h2, 2'h0, 16'h1030), 16'h0fff, 3'b110);
      run(32'h1, w2(2'h0, 2'h0, 16'h0000), 16'h0001, 3'b001);
      // Reserved type: blocked, faulted, flagged
      wr(`PIRC_OFF_CLEAR, 32'h7);
      run(PM, w2(2'h3, 2'h0, 16'h1234), 16'h1234, 3'b110);
      rdc("status", `PIRC_OFF_STATUS, 32'h7);
      wr(`PIRC_OFF_ENABLE, 32'h2);
      cmp("irq", 32'h1, {31'h0, irq});
      wr(`PIRC_OFF_CLEAR, 32'h7);
      cmp("irq", 32'h0, {31'h0, irq});
      // Fault reporting off: done only, irq stays masked
      run(PM | 32'h2, w2(2'h1, 2'h0, 16'h1234), 16'h0034, 3'b110);
      rdc("status", `PIRC_OFF_STATUS, 32'h1);
      rdc("req", `PIRC_OFF_REQ, 32'h0000_0034);
      cmp("irq", 32'h0, {31'h0, irq});
      // Present entry with matching id 1234, started from the request pins
      wr(`PIRC_OFF_ENTRY0, PM);
      u_pirc_io_dev.send(16'h1234);
      repeat (6) @(posedge pclk);
      cmp("pins", 32'h1, {30'h0, req_block, req_accept});
      end_of_test();
   end
endmodule
`default_nettype wire
